// *** rtl/shsc_standby_ctrl.sv ***
// Standby controller: HALT/STOP entry, release waits, timer gating
`timescale 1ns/1ns
module shsc_standby_ctrl #(
    parameter int RST_WAIT = shsc_pkg::RST_WAIT_CYC,
    parameter int STOP_WAIT = shsc_pkg::STOP_WAIT_CYC,
    parameter int HALT_VEC = shsc_pkg::HALT_VEC_WAIT,
    parameter int HALT_NXT = shsc_pkg::HALT_NXT_WAIT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Processor side
    input wire logic haltExec,
    input wire logic stopExec,
    input wire logic [7:0] portLatchIn,
    input wire logic portLatchWe,
    // Interrupt flags
    input wire logic [shsc_pkg::NUM_IRQ-1:0] interrupt_request_flag,
    input wire logic [shsc_pkg::NUM_IRQ-1:0] interrupt_mask_flag,
    input wire logic global_interrupt_enable,
    // Slow oscillator control
    input wire logic slowOscStoppable,
    input wire logic slowOscStopReq,
    input wire logic slowOscTick,
    input wire logic timerOnSlowClk,
    input wire logic [3:0] timerPrescale,
    // Outputs
    output logic cpuClkEn,
    output logic sysOscEn,
    output logic slowOscEn,
    output logic cpuHold,
    output logic vectorReq,
    output logic resumeNext,
    output logic resetVector,
    output logic timerTick,
    output logic [7:0] portLatchOut,
    output logic [7:0] timerCount,
    output logic [5:0] stateOut
);
    import shsc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        shsc_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [31:0] pre;
        logic vecPend;
        logic cpuClkEn;
        logic sysOscEn;
        logic slowOscEn;
        logic cpuHold;
        logic vectorReq;
        logic resumeNext;
        logic resetVector;
        logic timerTick;
        logic [7:0] port;
        logic [7:0] tcnt;
        logic stopOpt;
    } shsc_regs_t;

    shsc_regs_t r_q, r_d;

    function automatic logic anyUnmasked(input logic [NUM_IRQ-1:0] req,
                                         input logic [NUM_IRQ-1:0] msk,
                                         input logic [NUM_IRQ-1:0] en);
        anyUnmasked = |(req & ~msk & en);
    endfunction : anyUnmasked

    logic [NUM_IRQ-1:0] stopWake;
    logic wakeHalt, wakeStop, slowRun, preTick, timerAdv;

    always_comb begin
        stopWake = STOP_WAKE_MASK;
        stopWake[TMR_IRQ] = timerOnSlowClk;
        wakeHalt = anyUnmasked(interrupt_request_flag, interrupt_mask_flag,
                               {NUM_IRQ{1'b1}});
        wakeStop = anyUnmasked(interrupt_request_flag, interrupt_mask_flag,
                               stopWake);
        slowRun = ~(r_q.stopOpt & slowOscStopReq);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.vectorReq = 1'b0;
        r_d.resumeNext = 1'b0;
        r_d.resetVector = 1'b0;
        r_d.timerTick = 1'b0;
        r_d.slowOscEn = slowRun;
        // Prescaler runs off system clock; frozen in STOP
        if (r_q.st != SHSC_STOP && r_q.st != SHSC_OSC) begin
            r_d.pre = r_q.pre + 32'h1;
        end
        preTick = ~r_q.pre[timerPrescale] & r_d.pre[timerPrescale];
        if (timerOnSlowClk) begin
            timerAdv = slowOscTick & slowRun;
        end else begin
            timerAdv = preTick;
        end
        if (timerAdv && r_q.st != SHSC_RESET) begin
            r_d.tcnt = r_q.tcnt + 8'h1;
            r_d.timerTick = 1'b1;
        end
        // Port latch only written while running
        if (portLatchWe && r_q.st == SHSC_RUN && !haltExec && !stopExec) begin
            r_d.port = portLatchIn;
        end
        case (r_q.st)
            SHSC_RESET: begin
                // Option setting sampled all through the reset wait
                r_d.stopOpt = slowOscStoppable;
                if (r_q.cnt == '0) begin
                    r_d.st = SHSC_RUN;
                    r_d.cpuHold = 1'b0;
                    r_d.cpuClkEn = 1'b1;
                    r_d.resetVector = 1'b1;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end
            end
            SHSC_RUN: begin
                if (stopExec) begin
                    r_d.st = SHSC_STOP;
                    r_d.sysOscEn = 1'b0;
                    r_d.cpuClkEn = 1'b0;
                    r_d.cpuHold = 1'b1;
                    if (wakeStop) begin
                        r_d.st = SHSC_OSC;
                        r_d.sysOscEn = 1'b1;
                        r_d.cnt = CNT_W'(STOP_WAIT - 1);
                        r_d.vecPend = global_interrupt_enable;
                    end
                end else if (haltExec) begin
                    r_d.st = SHSC_HALT;
                    r_d.cpuClkEn = 1'b0;
                    r_d.cpuHold = 1'b1;
                    if (wakeHalt) begin
                        r_d.st = SHSC_WAIT;
                        r_d.vecPend = global_interrupt_enable;
                        r_d.cnt = global_interrupt_enable ?
                            CNT_W'(HALT_VEC - 2) : CNT_W'(HALT_NXT - 2);
                    end
                end
            end
            SHSC_HALT: begin
                if (wakeHalt) begin
                    r_d.st = SHSC_WAIT;
                    r_d.vecPend = global_interrupt_enable;
                    r_d.cnt = global_interrupt_enable ?
                        CNT_W'(HALT_VEC - 2) : CNT_W'(HALT_NXT - 2);
                end
            end
            SHSC_STOP: begin
                if (wakeStop) begin
                    r_d.st = SHSC_OSC;
                    r_d.sysOscEn = 1'b1;
                    r_d.cnt = CNT_W'(STOP_WAIT - 1);
                    r_d.vecPend = global_interrupt_enable;
                end
            end
            SHSC_OSC: begin
                if (r_q.cnt == '0) begin
                    r_d.st = SHSC_WAIT;
                    r_d.cnt = '0;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end
            end
            SHSC_WAIT: begin
                if (r_q.cnt == '0) begin
                    r_d.st = SHSC_RUN;
                    r_d.cpuClkEn = 1'b1;
                    r_d.cpuHold = 1'b0;
                    r_d.vectorReq = r_q.vecPend;
                    r_d.resumeNext = ~r_q.vecPend;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end
            end
            default: begin
                r_d.st = SHSC_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // Reset overrides HALT/STOP; oscillator restarts, wait runs
            r_q.st <= SHSC_RESET;
            r_q.cnt <= CNT_W'(RST_WAIT - 1);
            r_q.pre <= 32'h0;
            r_q.vecPend <= 1'b0;
            r_q.cpuClkEn <= 1'b0;
            r_q.sysOscEn <= 1'b1;
            r_q.slowOscEn <= 1'b1;
            r_q.cpuHold <= 1'b1;
            r_q.vectorReq <= 1'b0;
            r_q.resumeNext <= 1'b0;
            r_q.resetVector <= 1'b0;
            r_q.timerTick <= 1'b0;
            r_q.port <= 8'h00;
            r_q.tcnt <= 8'h00;
            r_q.stopOpt <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign cpuClkEn = r_q.cpuClkEn;
    assign sysOscEn = r_q.sysOscEn;
    assign slowOscEn = r_q.slowOscEn;
    assign cpuHold = r_q.cpuHold;
    assign vectorReq = r_q.vectorReq;
    assign resumeNext = r_q.resumeNext;
    assign resetVector = r_q.resetVector;
    assign timerTick = r_q.timerTick;
    assign portLatchOut = r_q.port;
    assign timerCount = r_q.tcnt;
    assign stateOut = r_q.st;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All checks share the one clock; reset silences them
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence haltEntry;
        r_q.st == SHSC_RUN && haltExec && !stopExec && !wakeHalt;
    endsequence

    sequence haltWake;
        r_q.st == SHSC_HALT && wakeHalt;
    endsequence

    sequence stopEntryPending;
        r_q.st == SHSC_RUN && stopExec && wakeStop;
    endsequence

    sequence stopRelease;
        r_q.st == SHSC_STOP && wakeStop;
    endsequence

    a_halt_entry: assert property (
        haltEntry |=> r_q.st == SHSC_HALT && !cpuClkEn)
        else $error("halt not entered");
    a_halt_clock_gated: assert property (
        r_q.st == SHSC_HALT |-> !cpuClkEn && sysOscEn)
        else $error("halt clock state wrong");
    a_stop_osc_off: assert property (
        r_q.st == SHSC_STOP |-> !sysOscEn && !cpuClkEn)
        else $error("stop oscillator not off");
    a_port_hold: assert property (
        (r_q.st == SHSC_HALT || r_q.st == SHSC_STOP) |=> $stable(portLatchOut))
        else $error("port latch changed in standby");
    a_stop_frozen: assert property (
        r_q.st == SHSC_STOP && !timerOnSlowClk |=> $stable(timerCount))
        else $error("prescaled timer ran in stop");
    a_halt_vec_wait: assert property (
        haltWake ##0 global_interrupt_enable |-> ##[11:13] vectorReq)
        else $error("vector wait out of range");
    a_halt_nxt_wait: assert property (
        haltWake ##0 !global_interrupt_enable |-> ##[3:5] resumeNext)
        else $error("resume wait out of range");
    a_pend_wake: assert property (
        r_q.st == SHSC_RUN && haltExec && !stopExec && wakeHalt
        |=> r_q.st == SHSC_WAIT)
        else $error("pending request did not release");
    a_stop_pend_wake: assert property (
        stopEntryPending |=> r_q.st == SHSC_OSC && sysOscEn && !cpuClkEn)
        else $error("pending request did not cancel stop");
    a_stop_release: assert property (
        stopRelease |=> r_q.st == SHSC_OSC && sysOscEn)
        else $error("stop not released by request");
    a_reset_vec: assert property (
        $fell(sys_rst) |-> (!resetVector) [*8])
        else $error("reset wait too short");
endmodule : shsc_standby_ctrl

// *** rtl/shsc_pkg.sv ***
// Package: constants and types for the standby halt/stop controller
package shsc_pkg;
    // Clock rate in kHz (25 MHz)
    localparam int CLK_KHZ = 25000;
    // Release and reset hold times in ns
    localparam int STOP_WAIT_MIN_NS = 17000;
    localparam int STOP_WAIT_TYP_NS = 34000;
    localparam int STOP_WAIT_MAX_NS = 67000;
    localparam int RST_WAIT_MIN_NS = 277000;
    localparam int RST_WAIT_TYP_NS = 544000;
    localparam int RST_WAIT_MAX_NS = 1075000;
    // Typical waits in cycles: ns * kHz / 1e6
    localparam int STOP_WAIT_CYC = STOP_WAIT_TYP_NS / 1000 * CLK_KHZ / 1000;
    localparam int RST_WAIT_CYC = RST_WAIT_TYP_NS / 1000 * CLK_KHZ / 1000;
    // Halt release waits in clocks
    localparam int HALT_VEC_WAIT = 12;
    localparam int HALT_NXT_WAIT = 4;
    localparam int CNT_W = 16;
    // Interrupt source count
    localparam int NUM_IRQ = 8;
    // Index of the 8-bit timer source
    localparam int TMR_IRQ = 0;
    // Sources allowed to wake STOP (timer only when on the slow clock, voltage detector, externals)
    localparam logic [NUM_IRQ-1:0] STOP_WAKE_MASK = 8'hff;
    // Timer prescaler width
    localparam int PRE_W = 12;
    localparam int SLOW_DIV_W = 7;

    typedef enum logic [5:0] {
        SHSC_RESET = 6'h01,
        SHSC_RUN = 6'h02,
        SHSC_HALT = 6'h04,
        SHSC_STOP = 6'h08,
        SHSC_WAIT = 6'h10,
        SHSC_OSC = 6'h20
    } shsc_state_t;
endpackage : shsc_pkg

// *** verif/shsc_core.sv ***
// Processor core and interrupt source model for the standby controller
`timescale 1ns/1ns
module shsc_core (
    // Clock
    input wire logic ref_clk,
    // Instruction and port side
    output logic haltExec,
    output logic stopExec,
    output logic [7:0] portLatchIn,
    output logic portLatchWe,
    // Interrupt flags
    output logic [shsc_pkg::NUM_IRQ-1:0] irqReq,
    output logic [shsc_pkg::NUM_IRQ-1:0] irqMask,
    output logic irqEnable
);
    import shsc_pkg::*;
    initial begin
        haltExec = 1'b0;
        stopExec = 1'b0;
        portLatchIn = 8'h00;
        portLatchWe = 1'b0;
        irqReq = 8'h00;
        irqMask = 8'hff;
        irqEnable = 1'b0;
    end
    // One-cycle instruction pulse; stop selects the deeper state
    task automatic execute(input logic stop);
        @(posedge ref_clk);
        haltExec <= !stop;
        stopExec <= stop;
        @(posedge ref_clk);
        haltExec <= 1'b0;
        stopExec <= 1'b0;
    endtask : execute
    // Data flips after the strobe so a stale latch is caught
    task automatic writePort(input logic [7:0] v);
        @(posedge ref_clk);
        portLatchIn <= v;
        portLatchWe <= 1'b1;
        @(posedge ref_clk);
        portLatchWe <= 1'b0;
        portLatchIn <= ~v;
    endtask : writePort
    task automatic setIrq(input logic [7:0] r, m, input logic ie);
        @(posedge ref_clk);
        irqReq <= r;
        irqMask <= m;
        irqEnable <= ie;
    endtask : setIrq
endmodule : shsc_core

// *** verif/tb.sv ***
// Self-checking testbench for the standby controller
`timescale 1ns/1ns
module tb;
    import shsc_pkg::*;
    localparam int RW = 20;
    localparam int SW = 10;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic slowOscStoppable = 1'b0;
    logic slowOscStopReq = 1'b0;
    logic slowOscTick = 1'b0;
    logic timerOnSlowClk = 1'b0;
    logic [3:0] timerPrescale = 4'h0;
    logic [2:0] slowDiv = 3'h0;
    logic haltExec, stopExec, portLatchWe, irqEnable;
    logic cpuClkEn, sysOscEn, slowOscEn, cpuHold, timerTick;
    logic vectorReq, resumeNext, resetVector;
    logic [7:0] portLatchIn, irqReq, irqMask, portLatchOut, timerCount;
    logic [5:0] stateOut;
    logic [2:0] pulses;
    int bad_count = 0;
    int checked = 0;
    assign pulses = {resetVector, resumeNext, vectorReq};
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Slow oscillator tick, one pulse every eight cycles
    always @(posedge ref_clk) begin
        slowDiv <= slowDiv + 3'h1;
        slowOscTick <= (slowDiv == 3'h7);
    end
    shsc_core u_shsc_core (.ref_clk(ref_clk), .haltExec(haltExec),
        .stopExec(stopExec), .portLatchIn(portLatchIn),
        .portLatchWe(portLatchWe), .irqReq(irqReq), .irqMask(irqMask),
        .irqEnable(irqEnable));
    shsc_standby_ctrl #(.RST_WAIT(RW), .STOP_WAIT(SW)) u_shsc_standby_ctrl (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .haltExec(haltExec),
        .stopExec(stopExec), .portLatchIn(portLatchIn),
        .portLatchWe(portLatchWe), .interrupt_request_flag(irqReq),
        .interrupt_mask_flag(irqMask), .global_interrupt_enable(irqEnable),
        .slowOscStoppable(slowOscStoppable), .slowOscStopReq(slowOscStopReq),
        .slowOscTick(slowOscTick), .timerOnSlowClk(timerOnSlowClk),
        .timerPrescale(timerPrescale), .cpuClkEn(cpuClkEn),
        .sysOscEn(sysOscEn), .slowOscEn(slowOscEn), .cpuHold(cpuHold),
        .vectorReq(vectorReq),
        .resumeNext(resumeNext), .resetVector(resetVector),
        .timerTick(timerTick), .portLatchOut(portLatchOut),
        .timerCount(timerCount), .stateOut(stateOut));
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : check
    task automatic inRange(input string nm, input int lo, hi, n);
        checked++;
        if (n < lo || n > hi) begin
            bad_count++;
            $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, n);
        end
    endtask : inRange
    // Edges after the sampling edge until the selected pulse
    task automatic waitPulse(input int sel, output int n);
        for (n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            #1;
            if (pulses[sel] === 1'b1) return;
        end
        bad_count++;
        $display("CHECK FAILED pulse %0d exp high got low", sel);
        summarize();
    endtask : waitPulse
    task automatic afterWake;
        check("run state", 8'h02, {2'h0, stateOut});
        check("cpu clock", 8'h01, {6'h0, cpuHold, cpuClkEn});
        @(posedge ref_clk);
        #1;
        check("pulse width", 8'h00, {5'h0, pulses});
        u_shsc_core.setIrq(8'h00, 8'hff, 1'b0);
    endtask : afterWake
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic doReset(input int cyc);
        int n;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (cyc) @(posedge ref_clk);
        #1;
        check("reset state", 8'h01, {2'h0, stateOut});
        check("reset port", 8'h00, portLatchOut);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        waitPulse(2, n);
        inRange("reset wait", RW - 1, RW + 2, n);
        check("reset cpu", 8'h01, {6'h0, cpuHold, cpuClkEn});
        $display("test reset done");
    endtask : doReset
    // Prescale 0 ticks every 2 clocks, prescale 1 every 4
    task automatic testHalt(input logic ie);
        int n;
        logic [7:0] t;
        logic [7:0] pv;
        pv = ie ? 8'h5a : 8'h69;
        @(posedge ref_clk);
        timerPrescale <= ie ? 4'h0 : 4'h1;
        u_shsc_core.writePort(pv);
        u_shsc_core.execute(1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        check("halt state", 8'h04, {2'h0, stateOut});
        check("halt clk", 8'h06, {5'h0, cpuHold, sysOscEn, cpuClkEn});
        u_shsc_core.writePort(~pv);
        u_shsc_core.setIrq(8'h02, 8'hff, ie);
        #1;
        t = timerCount;
        repeat (20) @(posedge ref_clk);
        #1;
        check("masked hold", 8'h04, {2'h0, stateOut});
        check("halt timer", ie ? 8'h0a : 8'h05, 8'(timerCount - t));
        u_shsc_core.setIrq(8'h02, 8'hfd, ie);
        waitPulse(ie ? 0 : 1, n);
        inRange("halt wake", ie ? 11 : 3, ie ? 13 : 5, n);
        afterWake();
        check("halt port", pv, portLatchOut);
        $display("test halt done");
    endtask : testHalt
    task automatic testPending;
        int n;
        u_shsc_core.setIrq(8'h04, 8'hfb, 1'b0);
        u_shsc_core.execute(1'b0);
        waitPulse(1, n);
        inRange("halt pending", 2, 4, n);
        check("run state", 8'h02, {2'h0, stateOut});
        u_shsc_core.execute(1'b1);
        waitPulse(1, n);
        inRange("stop pending", SW, SW + 3, n);
        afterWake();
        $display("test pending done");
    endtask : testPending
    task automatic testStop;
        int n;
        logic [7:0] t;
        u_shsc_core.writePort(8'h3c);
        u_shsc_core.execute(1'b1);
        repeat (2) @(posedge ref_clk);
        #1;
        check("stop state", 8'h08, {2'h0, stateOut});
        check("stop clocks", 8'h00, {6'h0, sysOscEn, cpuClkEn});
        t = timerCount;
        u_shsc_core.setIrq(8'h01, 8'hfe, 1'b1);
        repeat (20) @(posedge ref_clk);
        #1;
        check("timer no wake", 8'h08, {2'h0, stateOut});
        check("stop timer", t, timerCount);
        u_shsc_core.setIrq(8'h04, 8'hfb, 1'b1);
        waitPulse(0, n);
        inRange("stop wait", SW, SW + 2, n);
        afterWake();
        check("stop port", 8'h3c, portLatchOut);
        $display("test stop done");
    endtask : testStop
    // Slow tick every 8 clocks: 24 clocks hold exactly 3 ticks
    task automatic testSlow(input logic stoppable);
        int n;
        logic [7:0] t;
        logic [7:0] ticks;
        logic [7:0] expTicks;
        ticks = 8'h00;
        expTicks = stoppable ? 8'h00 : 8'h03;
        @(posedge ref_clk);
        timerOnSlowClk <= 1'b1;
        slowOscStopReq <= 1'b1;
        u_shsc_core.execute(1'b1);
        repeat (2) @(posedge ref_clk);
        #1;
        t = timerCount;
        repeat (24) begin
            @(posedge ref_clk);
            #1;
            if (timerTick === 1'b1) begin
                ticks = ticks + 8'h01;
            end
        end
        check("slow osc", {7'h0, !stoppable}, {7'h0, slowOscEn});
        check("slow timer", expTicks, 8'(timerCount - t));
        check("slow ticks", expTicks, ticks);
        if (!stoppable) begin
            u_shsc_core.setIrq(8'h01, 8'hfe, 1'b0);
            waitPulse(1, n);
            inRange("slow wake", SW, SW + 2, n);
            afterWake();
        end
        $display("test slow done");
    endtask : testSlow
    initial begin
        doReset(20);
        testHalt(1'b1);
        testHalt(1'b0);
        testPending();
        testStop();
        testSlow(1'b0);
        u_shsc_core.execute(1'b0);
        #1;
        check("halt before reset", 8'h04, {2'h0, stateOut});
        doReset(2);
        @(posedge ref_clk);
        slowOscStoppable <= 1'b1;
        doReset(2);
        testSlow(1'b1);
        check("stop before reset", 8'h08, {2'h0, stateOut});
        doReset(3);
        summarize();
    end
endmodule : tb
